/* File: rtl/tdf_diag.sv */
// diagnostic page: two-wire slave, live values, thresholds, flags and soft controls
`include "tdf_params.svh"
module tdf_diag (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic              tx_disable_pin,
	input  wire logic              tx_rate_select_pin,
	input  wire logic              rx_rate_select_pin,
	input  wire logic              tx_fault_src,
	input  wire logic              rx_sig_lost_src,
	input  wire logic              mon_valid,
	input  wire tdf_pkg::tdf_word_t mon_temp,
	input  wire tdf_pkg::tdf_word_t mon_vcc,
	input  wire tdf_pkg::tdf_word_t mon_bias,
	input  wire tdf_pkg::tdf_word_t mon_txpwr,
	input  wire tdf_pkg::tdf_word_t mon_rxpwr,
	output logic                   tx_fault_out,
	output logic                   rx_signal_lost_out,
	output logic                   tx_disable_eff,
	output logic                   tx_rate_high,
	output logic                   rx_rate_high,
	output logic                   data_ready_n
);
	import tdf_pkg::*;

	logic [2:0]  scl_s;
	logic [2:0]  sda_s;
	logic [1:0]  txdis_s;
	logic [1:0]  txrate_s;
	logic [1:0]  rxrate_s;
	logic [1:0]  fault_s;
	logic [1:0]  los_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	tdf_state_t  state;
	logic [3:0]  bitcnt;
	tdf_byte_t   shift;
	tdf_byte_t   tx_sh;
	tdf_byte_t   ptr;
	logic        is_read;
	logic        nack;
	logic        wr_en;
	logic        soft_txdis;
	logic        soft_rxrate;
	logic        soft_txrate;
	tdf_byte_t   thr [0:39];
	tdf_word_t   live [0:4];
	tdf_word_t   shadow [0:4];
	tdf_word_t   thr_w [0:19];
	logic [4:0]  ah;
	logic [4:0]  al;
	logic [4:0]  wh;
	logic [4:0]  wl;
	tdf_byte_t   stat_byte;
	tdf_byte_t   soft_byte;
	tdf_byte_t   alarm_lo;
	tdf_byte_t   alarm_hi;
	tdf_byte_t   warn_lo;
	tdf_byte_t   warn_hi;
	tdf_byte_t   rd_byte;
	tdf_byte_t   mem_rdata;
	tdf_byte_t   live_idx;
	logic        mem_we;

	// input synchronisers, the first stage feeds only the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end else begin
			scl_s <= {scl_s[1:0], scl_in};
			sda_s <= {sda_s[1:0], sda_in};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			txdis_s  <= 2'h0;
			txrate_s <= 2'h0;
			rxrate_s <= 2'h0;
			fault_s  <= 2'h0;
			los_s    <= 2'h0;
		end else begin
			txdis_s  <= {txdis_s[0], tx_disable_pin};
			txrate_s <= {txrate_s[0], tx_rate_select_pin};
			rxrate_s <= {rxrate_s[0], rx_rate_select_pin};
			fault_s  <= {fault_s[0], tx_fault_src};
			los_s    <= {los_s[0], rx_sig_lost_src};
		end
	end

	assign scl_rise  = scl_s[1] & ~scl_s[2];
	assign scl_fall  = ~scl_s[1] & scl_s[2];
	assign bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
	assign bus_stop  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

	// two-wire slave sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state   <= TDF_IDLE;
			bitcnt  <= 4'h0;
			shift   <= 8'h00;
			tx_sh   <= 8'h00;
			ptr     <= 8'h00;
			is_read <= 1'b0;
			nack    <= 1'b0;
			wr_en   <= 1'b0;
		end else begin
			wr_en <= 1'b0;
			if (bus_start) begin
				state  <= TDF_ADDR;
				bitcnt <= 4'h0;
			end else if (bus_stop) begin
				state <= TDF_IDLE;
			end else if (scl_rise) begin
				case (state)
					TDF_ADDR, TDF_PTR, TDF_WDATA: begin
						shift  <= {shift[6:0], sda_s[1]};
						bitcnt <= bitcnt + 4'h1;
					end
					TDF_RDATA: bitcnt <= bitcnt + 4'h1;
					TDF_RACK:  nack <= sda_s[1];
					default:   ;
				endcase
			end else if (scl_fall) begin
				case (state)
					TDF_ADDR: begin
						if (bitcnt == 4'h8) begin
							if (shift[7:1] == `TDF_DEV_ADDR) begin
								state   <= TDF_ADDR_ACK;
								is_read <= shift[0];
							end else begin
								state <= TDF_IDLE;
							end
						end
					end
					TDF_ADDR_ACK: begin
						bitcnt <= 4'h0;
						if (is_read) begin
							state <= TDF_RDATA;
							tx_sh <= rd_byte;
						end else begin
							state <= TDF_PTR;
						end
					end
					TDF_PTR: begin
						if (bitcnt == 4'h8) begin
							ptr   <= shift;
							state <= TDF_PTR_ACK;
						end
					end
					TDF_PTR_ACK: begin
						state  <= TDF_WDATA;
						bitcnt <= 4'h0;
					end
					TDF_WDATA: begin
						if (bitcnt == 4'h8) begin
							wr_en <= 1'b1;
							state <= TDF_WDATA_ACK;
						end
					end
					TDF_WDATA_ACK: begin
						ptr    <= ptr + 8'h01;
						state  <= TDF_WDATA;
						bitcnt <= 4'h0;
					end
					TDF_RDATA: begin
						if (bitcnt == 4'h8) begin
							state <= TDF_RACK;
							ptr   <= ptr + 8'h01;
						end else begin
							tx_sh <= {tx_sh[6:0], 1'b0};
						end
					end
					TDF_RACK: begin
						bitcnt <= 4'h0;
						if (nack) begin
							state <= TDF_IDLE;
						end else begin
							state <= TDF_RDATA;
							tx_sh <= rd_byte;
						end
					end
					default: state <= TDF_IDLE;
				endcase
			end
		end
	end

	// open-drain data line, only ever pulled low
	assign sda_out = 1'b0;
	always_comb begin
		case (state)
			TDF_ADDR_ACK, TDF_PTR_ACK, TDF_WDATA_ACK: sda_oe = 1'b1;
			TDF_RDATA: sda_oe = ~tx_sh[7];
			default:   sda_oe = 1'b0;
		endcase
	end

	// soft controls, applied the cycle after the write byte
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			soft_txdis  <= 1'b0;
			soft_rxrate <= 1'b0;
			soft_txrate <= 1'b0;
		end else if (wr_en) begin
			if (ptr == `TDF_OFS_STATUS) begin
				soft_txdis  <= shift[`TDF_BIT_SOFT_DIS];
				soft_rxrate <= shift[`TDF_BIT_SOFT_RATE];
			end
			if (ptr == `TDF_OFS_SOFT) begin
				soft_txrate <= shift[`TDF_BIT_SOFT_RATE];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_disable_eff     <= 1'b1;
			tx_rate_high       <= 1'b0;
			rx_rate_high       <= 1'b0;
			tx_fault_out       <= 1'b0;
			rx_signal_lost_out <= 1'b0;
		end else begin
			tx_disable_eff     <= soft_txdis | txdis_s[1];
			tx_rate_high       <= soft_txrate | txrate_s[1];
			rx_rate_high       <= soft_rxrate | rxrate_s[1];
			tx_fault_out       <= fault_s[1];
			rx_signal_lost_out <= los_s[1];
		end
	end

	// thresholds, writable byte pairs in bytes 0-39
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 40; i++) begin
				thr[i] <= 8'h00;
			end
		end else if (wr_en && ptr <= `TDF_OFS_THR_END) begin
			thr[ptr[5:0]] <= shift;
		end
	end

	// live values, and a per-transaction copy so pairs stay coherent
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 5; i++) begin
				live[i]   <= 16'h0000;
				shadow[i] <= 16'h0000;
			end
			data_ready_n <= 1'b1;
		end else begin
			if (mon_valid) begin
				live[0]      <= mon_temp;
				live[1]      <= mon_vcc;
				live[2]      <= mon_bias;
				live[3]      <= mon_txpwr;
				live[4]      <= mon_rxpwr;
				data_ready_n <= 1'b0;
			end
			if (bus_start) begin
				for (int i = 0; i < 5; i++) begin
					shadow[i] <= live[i];
				end
			end
		end
	end

	function automatic logic above(input tdf_word_t v, input tdf_word_t t, input logic sgn);
		above = sgn ? ($signed(v) > $signed(t)) : (v > t);
	endfunction

	// flags per channel, recomputed at each update
	genvar ch;
	generate
		for (ch = 0; ch < 5; ch++) begin : g_ch
			for (genvar k = 0; k < 4; k++) begin : g_thr
				assign thr_w[ch*4+k] = {thr[ch*8+k*2], thr[ch*8+k*2+1]};
			end
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					ah[ch] <= 1'b0;
					al[ch] <= 1'b0;
					wh[ch] <= 1'b0;
					wl[ch] <= 1'b0;
				end else if (mon_valid) begin
					ah[ch] <= above(live[ch], thr_w[ch*4], ch == 0);
					al[ch] <= above(thr_w[ch*4+1], live[ch], ch == 0);
					wh[ch] <= above(live[ch], thr_w[ch*4+2], ch == 0);
					wl[ch] <= above(thr_w[ch*4+3], live[ch], ch == 0);
				end
			end
		end
	endgenerate

	assign alarm_lo  = {ah[0], al[0], ah[1], al[1], ah[2], al[2], ah[3], al[3]};
	assign alarm_hi  = {ah[4], al[4], 6'h00};
	assign warn_lo   = {wh[0], wl[0], wh[1], wl[1], wh[2], wl[2], wh[3], wl[3]};
	assign warn_hi   = {wh[4], wl[4], 6'h00};
	assign stat_byte = {txdis_s[1], soft_txdis, txrate_s[1], rxrate_s[1],
		soft_rxrate, tx_fault_out, rx_signal_lost_out, data_ready_n};
	assign soft_byte = {4'h0, soft_txrate, 3'h0};

	// user memory above byte 127
	assign mem_we   = wr_en && ptr >= `TDF_OFS_USER_LO && ptr <= `TDF_OFS_USER_HI;
	assign live_idx = ptr - `TDF_OFS_LIVE;

	tdf_mem #(.AW(7), .DW(8)) u_mem (
		.ref_clk (ref_clk),
		.rst     (rst),
		.we      (mem_we),
		.waddr   (ptr[6:0]),
		.wdata   (shift),
		.raddr   (ptr[6:0]),
		.rdata   (mem_rdata)
	);

	// read data selection
	always_comb begin
		rd_byte = 8'h00;
		if (ptr[7]) begin
			rd_byte = mem_rdata;
		end else if (ptr <= `TDF_OFS_THR_END) begin
			rd_byte = thr[ptr[5:0]];
		end else if (ptr >= `TDF_OFS_LIVE && ptr <= `TDF_OFS_LIVE_END) begin
			rd_byte = live_idx[0] ? shadow[live_idx[3:1]][7:0]
				: shadow[live_idx[3:1]][15:8];
		end else begin
			case (ptr)
				`TDF_OFS_CKSUM:  rd_byte = `TDF_CKSUM_VAL;
				`TDF_OFS_STATUS: rd_byte = stat_byte;
				`TDF_OFS_ALM_LO: rd_byte = alarm_lo;
				`TDF_OFS_ALM_HI: rd_byte = alarm_hi;
				`TDF_OFS_WRN_LO: rd_byte = warn_lo;
				`TDF_OFS_WRN_HI: rd_byte = warn_hi;
				`TDF_OFS_SOFT:   rd_byte = soft_byte;
				default:         rd_byte = 8'h00;
			endcase
		end
	end

	chk_temp_signed: assert property (@(posedge ref_clk) disable iff (rst)
		mon_valid && ($signed(live[0]) < $signed(thr_w[0])) |=> !ah[0])
		else $error("temperature high alarm ignores sign");
	chk_vcc_capture: assert property (@(posedge ref_clk) disable iff (rst)
		mon_valid |=> live[1] == $past(mon_vcc))
		else $error("supply value not captured");
	chk_bias_low: assert property (@(posedge ref_clk) disable iff (rst)
		mon_valid && live[2] < thr_w[9] |=> al[2] && alarm_lo[2])
		else $error("bias low alarm missing");
	chk_rx_warn: assert property (@(posedge ref_clk) disable iff (rst)
		mon_valid && live[4] > thr_w[18] |=> warn_hi[7])
		else $error("receive power high warning missing");
	chk_pin_mirror: assert property (@(posedge ref_clk) disable iff (rst)
		stat_byte[7] == $past(tx_disable_pin, 2))
		else $error("disable pin state not mirrored");
	chk_dis_or: assert property (@(posedge ref_clk) disable iff (rst)
		(soft_txdis || txdis_s[1]) |=> tx_disable_eff)
		else $error("transmitter not disabled");
	chk_soft_resp: assert property (@(posedge ref_clk) disable iff (rst)
		wr_en && ptr == `TDF_OFS_SOFT && shift[3] |-> ##[1:2] tx_rate_high)
		else $error("soft rate command too slow");
	chk_ready_low: assert property (@(posedge ref_clk) disable iff (rst)
		mon_valid |=> !data_ready_n && !stat_byte[0])
		else $error("data ready not shown");
	chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(ptr == `TDF_OFS_ALM_HI || ptr == `TDF_OFS_WRN_HI) |-> rd_byte[5:0] == 6'h00)
		else $error("reserved flag bits set");
	chk_power_level: assert property (@(posedge ref_clk) disable iff (rst)
		ptr == `TDF_OFS_SOFT |-> rd_byte[7:4] == 4'h0 && rd_byte[2:0] == 3'h0)
		else $error("reserved or power level bits set");
	chk_cksum_fixed: assert property (@(posedge ref_clk) disable iff (rst)
		ptr == `TDF_OFS_CKSUM |-> rd_byte == `TDF_CKSUM_VAL)
		else $error("checksum byte changed");
endmodule

/* File: rtl/tdf_mem.sv */
// user byte memory with registered read
module tdf_mem #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

/* File: rtl/tdf_params.svh */
// offsets, bit positions, scale factors and timing figures of the diagnostic page
// Notes on behaviour
// - temperature is signed 16 bits, 1/256 degree steps
// - supply is unsigned 16 bits, 100 uV steps
// - bias is unsigned 16 bits, 2 uA steps
// - optical powers unsigned 16 bits, 0.1 uW steps
// - status bit 7 shows transmit-disable pin level
// - status bit 6 soft disable, ORed with pin
// - status bits 5,4 show rate-select pin levels
// - status bit 3 soft receive rate, ORed with pin
// - status bits 2,1 mirror fault and signal-lost outputs
// - status bit 0 low once monitor data valid
// - soft commands take effect within 100 ms
// - alarm byte 112 holds eight threshold alarm flags
// - alarm byte 113 holds receive power alarms
// - warning byte 116 mirrors alarm byte 112 order
// - warning byte 117 holds receive power warnings
// - byte 118 bit 3 soft transmit rate, ORed
// - byte 118 bit 1 reads zero, select unused
// - byte 95 fixed checksum, never updated
// - live values as byte pairs from byte 96
// - thresholds as byte pairs in bytes 0-39
`ifndef TDF_PARAMS_SVH
`define TDF_PARAMS_SVH

`define TDF_DEV_ADDR      7'h51
`define TDF_OFS_CKSUM     8'h5F
`define TDF_OFS_LIVE      8'h60
`define TDF_OFS_LIVE_END  8'h69
`define TDF_OFS_STATUS    8'h6E
`define TDF_OFS_ALM_LO    8'h70
`define TDF_OFS_ALM_HI    8'h71
`define TDF_OFS_WRN_LO    8'h74
`define TDF_OFS_WRN_HI    8'h75
`define TDF_OFS_SOFT      8'h76
`define TDF_OFS_THR_END   8'h27
`define TDF_OFS_USER_LO   8'h80
`define TDF_OFS_USER_HI   8'hF7
`define TDF_BIT_SOFT_DIS  6
`define TDF_BIT_SOFT_RATE 3
`define TDF_CKSUM_VAL     8'h00
`define TDF_TEMP_LSB_DIV  256
`define TDF_VCC_LSB_UV    100
`define TDF_BIAS_LSB_UA   2
`define TDF_PWR_LSB_NW    100
`define TDF_SOFT_RESP_MS  100

`endif

/* File: rtl/tdf_pkg.sv */
// types of the diagnostic page block
package tdf_pkg;
	typedef logic [15:0] tdf_word_t;
	typedef logic [7:0]  tdf_byte_t;
	typedef enum logic [3:0] {
		TDF_IDLE, TDF_ADDR, TDF_ADDR_ACK, TDF_PTR, TDF_PTR_ACK,
		TDF_WDATA, TDF_WDATA_ACK, TDF_RDATA, TDF_RACK
	} tdf_state_t;
endpackage

/* File: verification/tdf_host.sv */
// two-wire host controller model for the diagnostic page
`include "tdf_params.svh"
module tdf_host (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_w
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic put_bit(input logic b);
		#20 sda_drv = b;
		#20 scl = 1'b1;
		#40 scl = 1'b0;
	endtask
	task automatic get_bit(output logic b);
		sda_drv = 1'b1;
		#40 scl = 1'b1;
		#20 b = sda_w;
		#20 scl = 1'b0;
	endtask
	// start or repeated start; waits out the device releasing its ack
	task automatic start_c();
		#40 sda_drv = 1'b1;
		#40 scl = 1'b1;
		#40 sda_drv = 1'b0;
		#40 scl = 1'b0;
	endtask
	// stop, then the clock stands high between frames
	task automatic stop_c();
		#20 sda_drv = 1'b0;
		#20 scl = 1'b1;
		#40 sda_drv = 1'b1;
		#40;
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(b[i]);
		get_bit(a);
		ack = ~a;
	endtask
	task automatic recv(output logic [7:0] b, input logic last);
		for (int i = 7; i >= 0; i--) get_bit(b[i]);
		put_bit(last);
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat,
		output logic ok);
		logic a, b, c;
		start_c();
		send({dev, 1'b0}, a);
		send(ptr, b);
		send(dat, c);
		stop_c();
		ok = a & b & c;
	endtask
	// both bytes of a pair come from one transaction
	task automatic rd(input logic [7:0] ptr, output logic [15:0] w);
		logic a;
		start_c();
		send({`TDF_DEV_ADDR, 1'b0}, a);
		send(ptr, a);
		start_c();
		send({`TDF_DEV_ADDR, 1'b1}, a);
		recv(w[15:8], 1'b0);
		recv(w[7:0], 1'b1);
		stop_c();
	endtask
endmodule

/* File: verification/test_transceiver_diag_status_flags.sv */
// testbench of the diagnostic page block
`include "tdf_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_transceiver_diag_status_flags;
	timeunit 1ns;
	timeprecision 1ps;
	import tdf_pkg::*;
	logic      ref_clk, rst, scl, host_sda, sda_w, sda_out, sda_oe;
	logic      tx_disable_pin, tx_rate_select_pin, rx_rate_select_pin;
	logic      tx_fault_src, rx_sig_lost_src, mon_valid, ok;
	tdf_word_t mon_temp, mon_vcc, mon_bias, mon_txpwr, mon_rxpwr;
	logic      tx_fault_out, rx_signal_lost_out, tx_disable_eff;
	logic      tx_rate_high, rx_rate_high, data_ready_n;
	int        miscompares, n_tests, cycles;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & host_sda;
	tdf_diag tdf_diag_i (
		.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .tx_disable_pin(tx_disable_pin),
		.tx_rate_select_pin(tx_rate_select_pin), .rx_rate_select_pin(rx_rate_select_pin),
		.tx_fault_src(tx_fault_src), .rx_sig_lost_src(rx_sig_lost_src), .mon_valid(mon_valid),
		.mon_temp(mon_temp), .mon_vcc(mon_vcc), .mon_bias(mon_bias),
		.mon_txpwr(mon_txpwr), .mon_rxpwr(mon_rxpwr), .tx_fault_out(tx_fault_out),
		.rx_signal_lost_out(rx_signal_lost_out), .tx_disable_eff(tx_disable_eff),
		.tx_rate_high(tx_rate_high), .rx_rate_high(rx_rate_high),
		.data_ready_n(data_ready_n)
	);
	tdf_host tdf_host_i (.scl(scl), .sda_drv(host_sda), .sda_w(sda_w));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wrb(input logic [7:0] p, input logic [7:0] d);
		tdf_host_i.wr(`TDF_DEV_ADDR, p, d, ok);
		`CHK(ok, 1'b1)
	endtask
	task automatic rdw(input logic [7:0] p, input logic [15:0] e);
		logic [15:0] w;
		tdf_host_i.rd(p, w);
		`CHK(w, e)
	endtask
	task automatic mon_update();
		tick(1);
		repeat (2) begin
			mon_valid = 1'b1;
			tick(1);
			mon_valid = 1'b0;
			tick(3);
		end
	endtask
	task automatic outs(input logic d, input logic r, input logic t);
		tick(4);
		`CHK({tx_disable_eff, rx_rate_high, tx_rate_high}, {d, r, t})
	endtask
	initial begin
		{rst, tx_disable_pin, tx_rate_select_pin, rx_rate_select_pin} = 4'h8;
		{tx_fault_src, rx_sig_lost_src, mon_valid} = 3'h0;
		{mon_temp, mon_vcc, mon_bias, mon_txpwr, mon_rxpwr} = '0;
		tick(16);
		`CHK({tx_disable_eff, data_ready_n, sda_oe}, 3'h6)
		rst = 1'b0;
		tick(4);
		rdw(`TDF_OFS_STATUS, 16'h0100);
		$display("test reset done");
		{tx_disable_pin, rx_rate_select_pin, tx_fault_src} = 3'h7;
		outs(1'b1, 1'b1, 1'b0);
		`CHK({tx_fault_out, rx_signal_lost_out}, 2'h2)
		rdw(`TDF_OFS_STATUS, 16'h9500);
		{tx_disable_pin, rx_rate_select_pin, tx_fault_src} = 3'h0;
		{tx_rate_select_pin, rx_sig_lost_src} = 2'h3;
		outs(1'b0, 1'b0, 1'b1);
		`CHK({tx_fault_out, rx_signal_lost_out}, 2'h1)
		rdw(`TDF_OFS_STATUS, 16'h2300);
		{tx_rate_select_pin, rx_sig_lost_src} = 2'h0;
		$display("test pins done");
		wrb(`TDF_OFS_STATUS, 8'hFF);
		rdw(`TDF_OFS_STATUS, 16'h4900);
		outs(1'b1, 1'b1, 1'b0);
		wrb(`TDF_OFS_SOFT, 8'hFF);
		rdw(`TDF_OFS_SOFT, 16'h0800);
		outs(1'b1, 1'b1, 1'b1);
		wrb(`TDF_OFS_STATUS, 8'h00);
		wrb(`TDF_OFS_SOFT, 8'h00);
		outs(1'b0, 1'b0, 1'b0);
		$display("test soft done");
		wrb(8'h00, 8'h19);
		wrb(8'h02, 8'hF6);
		wrb(8'h0C, 8'hFF);
		wrb(8'h0D, 8'hFF);
		rdw(8'h00, 16'h1900);
		rdw(8'h02, 16'hF600);
		wrb(`TDF_OFS_CKSUM, 8'hA5);
		rdw(`TDF_OFS_CKSUM, {`TDF_CKSUM_VAL, 8'h00});
		wrb(8'h80, 8'h5A);
		wrb(8'h81, 8'hC3);
		rdw(8'h80, 16'h5AC3);
		mon_temp = 16'hEC00;
		mon_vcc = 16'h8100;
		mon_bias = 16'h1234;
		mon_txpwr = 16'h0ABC;
		mon_rxpwr = 16'h0DEF;
		mon_update();
		`CHK(data_ready_n, 1'b0)
		rdw(`TDF_OFS_LIVE, 16'hEC00);
		rdw(8'h62, 16'h8100);
		rdw(8'h64, 16'h1234);
		rdw(8'h66, 16'h0ABC);
		rdw(8'h68, 16'h0DEF);
		rdw(`TDF_OFS_ALM_LO, 16'h6A80);
		rdw(`TDF_OFS_WRN_LO, 16'h4A80);
		rdw(`TDF_OFS_STATUS, 16'h0000);
		mon_temp = 16'h0000;
		mon_rxpwr = 16'h0000;
		wrb(8'h12, 8'h20);
		mon_update();
		rdw(`TDF_OFS_ALM_LO, 16'h2E00);
		rdw(`TDF_OFS_WRN_LO, 16'h0A00);
		$display("test monitor done");
		tdf_host_i.wr(7'h50, `TDF_OFS_STATUS, 8'h40, ok);
		`CHK(ok, 1'b0)
		outs(1'b0, 1'b0, 1'b0);
		rdw(`TDF_OFS_STATUS, 16'h0000);
		$display("test address done");
		complete_run();
	end
endmodule
